// file: cms_pkg.sv
// Constants, register map and types of the counter mode sequencer
`default_nettype none
package cms_pkg;
	// ==========================================================
	// Widths
	localparam int unsigned CNT_W = 16;
	localparam int unsigned MODE_W = 7;

	// ==========================================================
	// Register byte offsets
	localparam logic [7:0] OFS_MODE = 8'h00;
	localparam logic [7:0] OFS_CMD = 8'h04;
	localparam logic [7:0] OFS_LOAD = 8'h08;
	localparam logic [7:0] OFS_HOLD = 8'h0C;
	localparam logic [7:0] OFS_COUNT = 8'h10;
	localparam logic [7:0] OFS_STATUS = 8'h14;

	// ==========================================================
	// Field positions
	localparam int unsigned MODE_REP_BIT = 0;
	localparam int unsigned MODE_RSRC_BIT = 1;
	localparam int unsigned MODE_SPEC_BIT = 2;
	localparam int unsigned MODE_TOG_BIT = 3;
	localparam int unsigned MODE_GC_LSB = 4;
	localparam int unsigned CMD_ARM_BIT = 0;
	localparam int unsigned CMD_DISARM_BIT = 1;
	localparam int unsigned CMD_LOAD_BIT = 2;
	localparam int unsigned ST_ARMED_BIT = 0;
	localparam int unsigned ST_TC_BIT = 1;
	localparam int unsigned ST_OUT_BIT = 2;
	localparam int unsigned ST_TRIG_BIT = 3;
	localparam int unsigned ST_PHASE_BIT = 4;
	localparam int unsigned ST_PEND_BIT = 5;

	// ==========================================================
	// Gate control field codes
	localparam logic [2:0] GC_NONE = 3'h0;
	localparam logic [2:0] GC_LEVEL_HI = 3'h1;
	localparam logic [2:0] GC_LEVEL_LO = 3'h2;
	localparam logic [2:0] GC_EDGE_RISE = 3'h3;
	localparam logic [2:0] GC_EDGE_FALL = 3'h4;

	// ==========================================================
	// Values after reset, and the count step of one
	localparam logic [MODE_W-1:0] RST_MODE = 7'h00;
	localparam logic [CNT_W-1:0] RST_CNT = 16'h0000;
	localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;

	// ==========================================================
	// Which terminal count of a two-count cycle comes next
	typedef enum logic {CMS_TC_FIRST, CMS_TC_SECOND} cms_tc_phase_e;
endpackage
`default_nettype wire

// file: cms_pin_sync.sv
// Three-stage pin synchroniser with filtered level and edge pulses
`default_nettype none
module cms_pin_sync (
	input wire logic hclk, // Clock
	input wire logic hresetn, // Async reset, active low
	input wire logic pin, // Asynchronous pin
	output logic level, // Filtered level
	output logic rise, // One-cycle pulse on rising change
	output logic fall // One-cycle pulse on falling change
);
	logic s1_reg;
	logic s2_reg;
	logic s3_reg;
	logic lvl_reg;
	logic rise_reg;
	logic fall_reg;
	logic agree;

	// ==========================================================
	// Synchroniser chain
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			s1_reg <= 1'b0;
			s2_reg <= 1'b0;
			s3_reg <= 1'b0;
		end
		else
		begin
			s1_reg <= pin;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end

	// ==========================================================
	// Level change accepted once stages two and three agree
	assign agree = (s2_reg == s3_reg);

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			lvl_reg <= 1'b0;
			rise_reg <= 1'b0;
			fall_reg <= 1'b0;
		end
		else
		begin
			lvl_reg <= agree ? s3_reg : lvl_reg; // RQ25
			rise_reg <= agree && s3_reg && !lvl_reg; // RQ25
			fall_reg <= agree && !s3_reg && lvl_reg; // RQ25
		end
	end

	assign level = lvl_reg;
	assign rise = rise_reg;
	assign fall = fall_reg;
endmodule
`default_nettype wire

// file: cms_sequencer.sv
// Counter mode sequencer with AHB-Lite register slave
`default_nettype none
// Summary of operation
// [RQ1] Software never selects the six reserved special-gate mode codes.
// [RQ2] No repetition, no reload source: one terminal count, then disarm.
// [RQ3] Reload source, no repetition: two terminal counts, then disarm.
// [RQ4] Repetition set: count to terminal count forever until disarm command.
// [RQ5] Gate control zero: gate never gates counting; special modes with reload source use it for reload.
// [RQ6] Non-special with reload source: reloads alternate Hold then Load.
// [RQ7] Special with reload source: gate low reloads Load, gate high reloads Hold.
// [RQ8] Special without reload source: gate edge saves count to Hold, then reloads Load.
// [RQ9] Level gating: only source edges during active gate level count, except the edge leaving terminal count.
// [RQ10] Single-shot software modes: reload Load, disarm, wait for new arm.
// [RQ11] Strobe mode starts after gate edge while armed; rearm before next.
// [RQ12] Edge modes ignore gate while disarmed and, unless special without reload source, after accepted trigger.
// [RQ13] Ungated rate generator reloads Load at each terminal count.
// [RQ14] Toggled output option flips output at each terminal count.
// [RQ15] Non-retriggerable one-shot: stops at terminal count, next gate edge restarts.
// [RQ16] Delayed pulse: first count reloads Hold, second reloads Load and disarms.
// [RQ17] Toggled delayed pulse: initial count sets delay, Hold sets width.
// [RQ18] Level-gated delayed pulse follows Hold-Load sequence counting only while gated.
// [RQ19] Delayed pulse strobe: start on armed gate edge, ignore gate until done.
// [RQ20] Variable duty generator: Hold on odd, Load on even counts, continuously.
// [RQ21] Level-gated variable duty: alternation restarts with Hold after each arm.
// [RQ22] Edge alternating mode: start on armed gate edge, stop at second count.
// [RQ23] Only active-going source and gate transitions count or act.
// [RQ24] Counter at terminal count always takes next source edge; stops follow it.
// [RQ25] Gate and source are synchronised and edge-detected on the internal clock.
module cms_sequencer (
	input wire logic hclk, // Bus clock
	input wire logic hresetn, // Async reset, active low
	input wire logic hsel, // Slave select
	input wire logic [31:0] haddr, // Byte address
	input wire logic [1:0] htrans, // Transfer type
	input wire logic hwrite, // Write when high
	input wire logic [2:0] hsize, // Transfer size, word only
	input wire logic [31:0] hwdata, // Write data
	input wire logic hready, // Bus ready
	output logic hreadyout, // Slave ready
	output logic hresp, // Response, always OKAY
	output logic [31:0] hrdata, // Read data
	input wire logic gate_in, // Gate pin, asynchronous
	input wire logic source_in, // Count source pin, asynchronous
	output logic counter_out, // Counter output
	output logic terminal_count // Counter sitting at terminal count
);
	localparam int unsigned W = cms_pkg::CNT_W;

	// ==========================================================
	// Gate control decode
	function automatic logic gate_is_level(input logic [2:0] gc);
		gate_is_level = (gc == cms_pkg::GC_LEVEL_HI) || (gc == cms_pkg::GC_LEVEL_LO);
	endfunction

	function automatic logic gate_is_edge(input logic [2:0] gc);
		gate_is_edge = (gc == cms_pkg::GC_EDGE_RISE) || (gc == cms_pkg::GC_EDGE_FALL);
	endfunction

	function automatic logic gate_active_high(input logic [2:0] gc);
		gate_active_high = (gc != cms_pkg::GC_LEVEL_LO) && (gc != cms_pkg::GC_EDGE_FALL);
	endfunction

	logic [cms_pkg::MODE_W-1:0] mode_reg;
	logic [W-1:0] load_reg;
	logic [W-1:0] hold_reg;
	logic [W-1:0] count_reg;
	logic armed_reg;
	logic tc_reg;
	logic tc_next;
	logic out_reg;
	logic trig_reg;
	logic pend_reg;
	cms_pkg::cms_tc_phase_e phase_reg;
	logic dph_wr_reg;
	logic [7:0] dph_addr_reg;
	logic [31:0] hrdata_reg;
	logic [31:0] rd_value;
	logic addr_phase;
	logic addr_ok;
	logic wr_mode;
	logic wr_cmd;
	logic wr_load;
	logic wr_hold;
	logic cmd_arm;
	logic cmd_disarm;
	logic cmd_load;
	logic rep;
	logic rsrc;
	logic spec;
	logic tog;
	logic [2:0] gc;
	logic lvl_mode;
	logic edge_mode;
	logic act_hi;
	logic gate_lvl;
	logic gate_rise;
	logic gate_fall;
	logic src_rise;
	logic gate_act;
	logic gate_edge;
	logic retrig_mode;
	logic gsel_mode;
	logic trig_accept;
	logic retrig_evt;
	logic qualify;
	logic cnt_edge;
	logic tc_leave;
	logic pend_use;
	logic dec;
	logic tc_enter;
	logic second;
	logic end_cycle;
	logic sel_hold;
	logic [W-1:0] reload_val;
	logic [W-1:0] ld_cmd_val;

	// ==========================================================
	// Pin synchronisers
	cms_pin_sync u_gate_sync (
		.hclk(hclk),
		.hresetn(hresetn),
		.pin(gate_in),
		.level(gate_lvl),
		.rise(gate_rise),
		.fall(gate_fall)
	);

	cms_pin_sync u_src_sync (
		.hclk(hclk),
		.hresetn(hresetn),
		.pin(source_in),
		.level(),
		.rise(src_rise),
		.fall()
	);

	// ==========================================================
	// AHB-Lite slave, zero wait states
	assign addr_phase = hsel && htrans[1] && hready;
	assign addr_ok = (haddr[31:8] == 24'h000000) && (haddr[1:0] == 2'h0);
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = hrdata_reg;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			dph_wr_reg <= 1'b0;
			dph_addr_reg <= 8'h00;
		end
		else
		begin
			dph_wr_reg <= addr_phase && hwrite && addr_ok;
			dph_addr_reg <= haddr[7:0];
		end
	end

	assign wr_mode = dph_wr_reg && (dph_addr_reg == cms_pkg::OFS_MODE);
	assign wr_cmd = dph_wr_reg && (dph_addr_reg == cms_pkg::OFS_CMD);
	assign wr_load = dph_wr_reg && (dph_addr_reg == cms_pkg::OFS_LOAD);
	assign wr_hold = dph_wr_reg && (dph_addr_reg == cms_pkg::OFS_HOLD);
	assign cmd_arm = wr_cmd && hwdata[cms_pkg::CMD_ARM_BIT];
	assign cmd_disarm = wr_cmd && hwdata[cms_pkg::CMD_DISARM_BIT];
	assign cmd_load = wr_cmd && hwdata[cms_pkg::CMD_LOAD_BIT];

	always_comb
	begin
		rd_value = 32'h00000000;
		case (haddr[7:0])
			cms_pkg::OFS_MODE: rd_value[cms_pkg::MODE_W-1:0] = mode_reg;
			cms_pkg::OFS_LOAD: rd_value[W-1:0] = load_reg;
			cms_pkg::OFS_HOLD: rd_value[W-1:0] = hold_reg;
			cms_pkg::OFS_COUNT: rd_value[W-1:0] = count_reg;
			cms_pkg::OFS_STATUS:
			begin
				rd_value[cms_pkg::ST_ARMED_BIT] = armed_reg;
				rd_value[cms_pkg::ST_TC_BIT] = tc_reg;
				rd_value[cms_pkg::ST_OUT_BIT] = out_reg;
				rd_value[cms_pkg::ST_TRIG_BIT] = trig_reg;
				rd_value[cms_pkg::ST_PHASE_BIT] = (phase_reg == cms_pkg::CMS_TC_SECOND);
				rd_value[cms_pkg::ST_PEND_BIT] = pend_reg;
			end
			default: rd_value = 32'h00000000;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			hrdata_reg <= 32'h00000000;
		else
			hrdata_reg <= (addr_phase && !hwrite && addr_ok) ? rd_value : 32'h00000000;
	end

	// ==========================================================
	// Configuration registers
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			mode_reg <= cms_pkg::RST_MODE;
			load_reg <= cms_pkg::RST_CNT;
		end
		else
		begin
			if (wr_mode)
				mode_reg <= hwdata[cms_pkg::MODE_W-1:0];
			if (wr_load)
				load_reg <= hwdata[W-1:0];
		end
	end

	// ==========================================================
	// Mode decode
	assign rep = mode_reg[cms_pkg::MODE_REP_BIT];
	assign rsrc = mode_reg[cms_pkg::MODE_RSRC_BIT];
	assign spec = mode_reg[cms_pkg::MODE_SPEC_BIT];
	assign tog = mode_reg[cms_pkg::MODE_TOG_BIT];
	assign gc = mode_reg[cms_pkg::MODE_GC_LSB +: 3];
	assign lvl_mode = gate_is_level(gc);
	assign edge_mode = gate_is_edge(gc);
	assign act_hi = gate_active_high(gc);
	assign gate_act = act_hi ? gate_lvl : !gate_lvl;
	assign gate_edge = act_hi ? gate_rise : gate_fall; // RQ23
	// Reserved codes are left to software to avoid
	assign retrig_mode = spec && !rsrc && (gc != cms_pkg::GC_NONE); // RQ1
	assign gsel_mode = spec && rsrc && (gc == cms_pkg::GC_NONE); // RQ5
	assign second = (phase_reg == cms_pkg::CMS_TC_SECOND);

	// ==========================================================
	// Trigger, retrigger and count qualification
	assign trig_accept = armed_reg && edge_mode && gate_edge && (retrig_mode || !trig_reg); // RQ12
	assign retrig_evt = retrig_mode && armed_reg && gate_edge; // RQ8
	assign qualify = (!lvl_mode || gate_act) && (!edge_mode || trig_reg); // RQ9
	assign cnt_edge = src_rise && (tc_reg || (armed_reg && qualify)); // RQ24
	assign tc_leave = cnt_edge && tc_reg; // RQ24
	assign pend_use = cnt_edge && !tc_reg && pend_reg; // RQ8
	assign dec = cnt_edge && !tc_reg && !pend_reg;
	assign tc_enter = dec && (count_reg == cms_pkg::CNT_ONE);
	// Two-count modes end their cycle only on the second terminal count
	assign end_cycle = !rsrc || second; // RQ3
	assign sel_hold = gsel_mode ? gate_lvl : (rsrc && !second); // RQ6 RQ7
	assign reload_val = sel_hold ? hold_reg : load_reg;
	assign ld_cmd_val = (gsel_mode && gate_lvl) ? hold_reg : load_reg; // RQ7

	// ==========================================================
	// Counter
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			count_reg <= cms_pkg::RST_CNT;
		else if (cmd_load)
			count_reg <= ld_cmd_val;
		else if (tc_leave)
			count_reg <= reload_val; // RQ13 RQ16 RQ20
		else if (pend_use)
			count_reg <= load_reg; // RQ8
		else if (dec)
			count_reg <= count_reg - cms_pkg::CNT_ONE;
	end

	always_comb
	begin
		tc_next = tc_reg;
		if (cmd_load || tc_leave || pend_use)
			tc_next = 1'b0;
		else if (tc_enter)
			tc_next = 1'b1;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			tc_reg <= 1'b0;
		else
			tc_reg <= tc_next;
	end

	// ==========================================================
	// Reload alternation phase
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			phase_reg <= cms_pkg::CMS_TC_FIRST;
		else if (cmd_arm)
			phase_reg <= cms_pkg::CMS_TC_FIRST; // RQ21
		else if (tc_leave && rsrc)
		begin
			case (phase_reg)
				cms_pkg::CMS_TC_FIRST: phase_reg <= cms_pkg::CMS_TC_SECOND; // RQ16 RQ18
				cms_pkg::CMS_TC_SECOND: phase_reg <= cms_pkg::CMS_TC_FIRST; // RQ20
				default: phase_reg <= cms_pkg::CMS_TC_FIRST;
			endcase
		end
	end

	// ==========================================================
	// Arming
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			armed_reg <= 1'b0;
		else if (cmd_arm)
			armed_reg <= 1'b1;
		else if (cmd_disarm)
			armed_reg <= 1'b0; // RQ4
		else if (tc_leave && !rep && end_cycle)
			armed_reg <= 1'b0; // RQ2 RQ3 RQ10 RQ19
	end

	// ==========================================================
	// Edge trigger latch, cleared where the count cycle ends
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			trig_reg <= 1'b0;
		else if (cmd_arm || cmd_disarm)
			trig_reg <= 1'b0;
		else if (trig_accept)
			trig_reg <= 1'b1; // RQ11 RQ19
		else if (tc_leave && end_cycle)
			trig_reg <= 1'b0; // RQ15 RQ22
	end

	// ==========================================================
	// Retrigger pending and Hold capture
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			pend_reg <= 1'b0;
		else if (retrig_evt)
			pend_reg <= 1'b1; // RQ8
		else if (cmd_load || pend_use || tc_leave)
			pend_reg <= 1'b0;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			hold_reg <= cms_pkg::RST_CNT;
		else if (retrig_evt)
			hold_reg <= count_reg; // RQ8
		else if (wr_hold)
			hold_reg <= hwdata[W-1:0];
	end

	// ==========================================================
	// Output: terminal count level, or toggled on each terminal count
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			out_reg <= 1'b0;
		else
			out_reg <= tog ? (out_reg ^ tc_enter) : tc_next; // RQ14 RQ17
	end

	assign counter_out = out_reg;
	assign terminal_count = tc_reg;

	// ==========================================================
	// Assertions
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	a_once_disarm: assert property (tc_leave && !rep && !rsrc && !cmd_arm |=> !armed_reg) // RQ2
		else $error("single count mode did not disarm");
	a_twice_disarm: assert property (tc_leave && !rep && rsrc && second && !cmd_arm
		|=> !armed_reg && phase_reg == cms_pkg::CMS_TC_FIRST) // RQ3
		else $error("two count mode did not disarm after second");
	a_repeat_armed: assert property (tc_leave && rep && armed_reg && !wr_cmd |=> armed_reg) // RQ4
		else $error("repeating mode disarmed itself");
	a_alt_hold: assert property (tc_leave && !spec && rsrc && !second && !cmd_load
		|=> count_reg == $past(hold_reg)) // RQ6
		else $error("first reload not from hold");
	a_gate_hold: assert property (tc_leave && gsel_mode && gate_lvl && !cmd_load
		|=> count_reg == $past(hold_reg)) // RQ7
		else $error("gate high reload not from hold");
	a_retrig_seq: assert property (retrig_evt && !cmd_load ##1 (!retrig_evt && !cmd_load)[*1]
		|-> hold_reg == $past(count_reg) && pend_reg) // RQ8
		else $error("retrigger did not capture count");
	a_level_block: assert property (src_rise && lvl_mode && !gate_act && !tc_reg && !cmd_load
		|=> $stable(count_reg)) // RQ9
		else $error("counted outside active gate level");
	a_single_load: assert property (tc_leave && !rep && !rsrc && !cmd_load
		|=> count_reg == $past(load_reg) && !tc_reg) // RQ10
		else $error("single shot did not reload from load");
	a_edge_disarmed: assert property (!armed_reg && !cmd_arm && edge_mode |=> !trig_reg) // RQ12
		else $error("gate edge accepted while disarmed");
	a_tc_always: assert property (src_rise && tc_reg && !pend_reg && !cmd_load |=> !tc_reg) // RQ24
		else $error("terminal count held past source edge");
	a_square_wave: assert property (tc_enter && tog |=> out_reg != $past(out_reg)) // RQ14
		else $error("toggled output did not flip");

	c_two_count: cover property (tc_leave && rsrc && second);
	c_retrig: cover property (retrig_evt ##[1:50] pend_use);
	c_gate_select: cover property (tc_leave && gsel_mode && gate_lvl);
	c_edge_start: cover property (trig_accept ##[1:100] tc_enter);
endmodule
`default_nettype wire

// file: cms_pin_model.sv
// Far-side model driving the gate and count source pins
`default_nettype none
module cms_pin_model (
	input wire logic hclk, // Clock
	input wire logic hresetn, // Reset, active low
	input wire logic gate_lvl, // Wanted gate level
	input wire logic pulse_req, // Request one source pulse
	output logic gate_in, // Gate pin
	output logic source_in, // Source pin
	output logic busy // Pulse in progress
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0] ph_reg;

	// ==========================================================
	// Source pulse: four cycles high, four low
	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn)
			ph_reg <= 4'h0;
		else if (pulse_req && ph_reg == 4'h0)
			ph_reg <= 4'h1;
		else if (ph_reg == 4'h8)
			ph_reg <= 4'h0;
		else if (ph_reg != 4'h0)
			ph_reg <= ph_reg + 4'h1;
	assign source_in = (ph_reg != 4'h0) && (ph_reg < 4'h5);
	assign busy = ph_reg != 4'h0;

	// ==========================================================
	// Gate level follows request
	always_ff @(posedge hclk or negedge hresetn)
		if (!hresetn)
			gate_in <= 1'b0;
		else
			gate_in <= gate_lvl;
endmodule
`default_nettype wire

// file: testbench.sv
// Self-checking bench for the counter mode sequencer
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	// ==========================================================
	// Clock, stimulus and wires
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h00000000;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h00000000;
	logic gate_lvl = 1'b0;
	logic pulse_req = 1'b0;
	wire logic hreadyout, hresp, counter_out, terminal_count, gate_in, source_in, busy;
	wire logic [31:0] hrdata;
	int n_errors = 0;
	int checks = 0;
	logic [31:0] rd;
	logic o;
	always #50 hclk = ~hclk;

	cms_sequencer DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.gate_in(gate_in), .source_in(source_in), .counter_out(counter_out),
		.terminal_count(terminal_count));
	cms_pin_model pins (.hclk(hclk), .hresetn(hresetn), .gate_lvl(gate_lvl),
		.pulse_req(pulse_req), .gate_in(gate_in), .source_in(source_in), .busy(busy));

	// ==========================================================
	// Reporting
	task automatic stop_test;
		$display("Checks %0d, errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic hang;
		n_errors++;
		$display("Error at %0t: wait ran out", $time);
		stop_test();
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("Error at %0t: read %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk_pin(input logic got, input logic exp);
		checks++;
		if (got !== exp)
		begin
			n_errors++;
			$display("Error at %0t: bit %b expected %b", $time, got, exp);
		end
	endtask

	// ==========================================================
	// Bus and pin access
	task automatic wait_rdy;
		int i;
		i = 0;
		@(posedge hclk);
		while (hreadyout !== 1'b1)
		begin
			i++;
			if (i > 20)
				hang();
			else
				@(posedge hclk);
		end
	endtask
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		htrans <= 2'h2;
		hwrite <= w;
		wait_rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy();
		rd = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'h00000000);
		chk(rd, exp);
	endtask
	task automatic armed(input logic exp);
		xfer(1'b0, cms_pkg::OFS_STATUS, 32'h00000000);
		chk_pin(rd[cms_pkg::ST_ARMED_BIT], exp);
	endtask
	task automatic cnt(input int n, input logic [31:0] exp);
		int i;
		int j;
		for (i = 0; i < n; i++)
		begin
			pulse_req <= 1'b1;
			@(posedge hclk);
			pulse_req <= 1'b0;
			j = 0;
			do
			begin
				@(posedge hclk);
				j++;
			end while (busy === 1'b1 && j < 30);
			if (j >= 30)
				hang();
		end
		rchk(cms_pkg::OFS_COUNT, exp);
	endtask
	task automatic gate(input logic v);
		gate_lvl <= v;
		repeat (8) @(posedge hclk);
	endtask
	task automatic setup(input logic [31:0] mode, input logic [31:0] ld, input logic [31:0] hd,
		input logic arm);
		wr(cms_pkg::OFS_CMD, 32'h00000002);
		wr(cms_pkg::OFS_MODE, mode);
		wr(cms_pkg::OFS_LOAD, ld);
		wr(cms_pkg::OFS_HOLD, hd);
		wr(cms_pkg::OFS_CMD, 32'h00000004);
		if (arm)
			wr(cms_pkg::OFS_CMD, 32'h00000001);
	endtask

	// ==========================================================
	// Main sequence
	initial
	begin
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		// Reset values, unmapped and write-only places
		rchk(cms_pkg::OFS_MODE, 32'h00000000);
		rchk(cms_pkg::OFS_STATUS, 32'h00000000);
		chk_pin(terminal_count, 1'b0);
		chk_pin(hresp, 1'b0);
		wr(8'h18, 32'hFFFFFFFF);
		rchk(8'h18, 32'h00000000);
		wr(cms_pkg::OFS_HOLD, 32'h0001ABCD);
		rchk(cms_pkg::OFS_HOLD, 32'h0000ABCD);
		rchk(cms_pkg::OFS_CMD, 32'h00000000);
		// Software strobe, single shot
		setup(32'h00, 32'h3, 32'h0, 1'b1);
		cnt(3, 32'h0);
		chk_pin(terminal_count, 1'b1);
		cnt(1, 32'h3);
		armed(1'b0);
		cnt(1, 32'h3);
		// Rate generator, toggled output
		setup(32'h09, 32'h2, 32'h0, 1'b1);
		o = counter_out;
		cnt(2, 32'h0);
		chk_pin(counter_out, ~o);
		cnt(1, 32'h2);
		armed(1'b1);
		cnt(2, 32'h0);
		chk_pin(counter_out, o);
		cnt(1, 32'h2);
		wr(cms_pkg::OFS_CMD, 32'h00000002);
		cnt(1, 32'h2);
		// Delayed pulse, toggled output
		setup(32'h0A, 32'h2, 32'h1, 1'b1);
		o = counter_out;
		cnt(2, 32'h0);
		chk_pin(counter_out, ~o);
		cnt(1, 32'h1);
		armed(1'b1);
		cnt(1, 32'h0);
		chk_pin(counter_out, o);
		cnt(1, 32'h2);
		armed(1'b0);
		// Level gating
		setup(32'h10, 32'h3, 32'h0, 1'b1);
		cnt(2, 32'h3);
		gate(1'b1);
		cnt(1, 32'h2);
		gate(1'b0);
		// Hardware-triggered strobe
		setup(32'h30, 32'h3, 32'h0, 1'b0);
		gate(1'b1);
		gate(1'b0);
		cnt(1, 32'h3);
		wr(cms_pkg::OFS_CMD, 32'h00000001);
		cnt(1, 32'h3);
		gate(1'b1);
		gate(1'b0);
		cnt(2, 32'h1);
		cnt(1, 32'h0);
		cnt(1, 32'h3);
		armed(1'b0);
		// Gate selects reload source
		gate(1'b1);
		setup(32'h06, 32'h3, 32'h1, 1'b1);
		rchk(cms_pkg::OFS_COUNT, 32'h1);
		cnt(1, 32'h0);
		gate(1'b0);
		cnt(1, 32'h3);
		// Level-gated retrigger
		setup(32'h14, 32'h5, 32'h0, 1'b1);
		gate(1'b1);
		cnt(1, 32'h5);
		cnt(2, 32'h3);
		gate(1'b0);
		gate(1'b1);
		rchk(cms_pkg::OFS_HOLD, 32'h3);
		cnt(1, 32'h5);
		// Variable duty rate generator
		setup(32'h03, 32'h2, 32'h1, 1'b1);
		cnt(2, 32'h0);
		cnt(1, 32'h1);
		cnt(1, 32'h0);
		cnt(1, 32'h2);
		armed(1'b1);
		cnt(3, 32'h1);
		// Non-retriggerable one-shot
		setup(32'h31, 32'h2, 32'h0, 1'b1);
		gate(1'b0);
		gate(1'b1);
		cnt(2, 32'h0);
		cnt(1, 32'h2);
		armed(1'b1);
		cnt(1, 32'h2);
		gate(1'b0);
		gate(1'b1);
		cnt(1, 32'h1);
		stop_test();
	end
endmodule
`default_nettype wire
